// *** rtl/acr_aux_control_registers.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acr_defines.svh"

module acr_aux_control_registers #(
   parameter int unsigned NVM_TO1_CYC = `ACR_NVM_TO1_CYC,
   parameter int unsigned NVM_TO2_CYC = `ACR_NVM_TO2_CYC,
   parameter int unsigned NVM_TO3_CYC = `ACR_NVM_TO3_CYC
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // Special function register port
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   output logic [7:0] sfr_rdata_out,
   // Core status
   input wire logic [3:0] run_mode_in,
   input wire logic conversion_done_in,
   input wire logic nvm_write_busy_in,
   // Controls to the surrounding units
   output logic watchdog_reset_enable_out,
   output logic low_power_select_out,
   output logic reference_pin_output_out,
   output logic wide_divide_select_out,
   output logic wide_muldiv_select_out,
   output logic nvm_write_timeout_flag_out,
   output logic watchdog_clear_strobe_out,
   output logic timer_three_clear_strobe_out,
   output logic conversion_start_out,
   output logic pulse_gen_zero_hold_clear_out,
   output logic pulse_gen_one_hold_clear_out,
   output logic data_pointer_select_out
);

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [7:0] aux_config_two;
   logic watchdog_clear_strobe;
   logic timer_three_clear_strobe;
   logic conversion_start;
   logic pulse_gen_zero_hold_clear;
   logic pulse_gen_one_hold_clear;
   logic data_pointer_select;
   logic [7:0] aux_control_one;
   logic wr_aux_config_two;
   logic wr_aux_control_one;
   logic [1:0] nvm_write_timeout_select;
   logic [1:0] watchdog_reset_policy;
   acr_pkg::acr_nvm_state_t nvm_state;
   logic [19:0] nvm_count;
   logic [19:0] nvm_limit;
   acr_pkg::acr_nvm_state_t next_nvm_state;
   logic nvm_armed;
   logic nvm_expired;
   logic mode_counts_watchdog;
   logic [7:0] next_sfr_rdata;

   // Cycle counts per timeout setting; a zero limit means the watch is off.
   function automatic logic [19:0] nvm_limit_of(input logic [1:0] sel);
      case (sel)
         2'h1: nvm_limit_of = 20'(NVM_TO1_CYC);
         2'h2: nvm_limit_of = 20'(NVM_TO2_CYC);
         2'h3: nvm_limit_of = 20'(NVM_TO3_CYC);
         default: nvm_limit_of = 20'h00000;
      endcase
   endfunction

   // Address decode is shared by the write enables and the read mux.
   function automatic logic addr_hits(input logic [7:0] addr, input logic [7:0] target);
      addr_hits = (addr == target);
   endfunction

   assign wr_aux_config_two = sfr_wr_in && addr_hits(sfr_addr_in, `ACR_ADDR_AUX_CONFIG_TWO);
   assign wr_aux_control_one = sfr_wr_in && addr_hits(sfr_addr_in, `ACR_ADDR_AUX_CONTROL_ONE);
   assign nvm_write_timeout_select = aux_config_two[`ACR_NVM_TO_HI:`ACR_NVM_TO_LO];
   assign watchdog_reset_policy = aux_config_two[`ACR_WDT_POLICY_HI:`ACR_WDT_POLICY_LO];
   assign nvm_limit = nvm_limit_of(nvm_write_timeout_select);

   // Bits 5 and 1 are tied low so they read zero and drop writes.
   assign aux_control_one = {watchdog_clear_strobe, timer_three_clear_strobe, 1'b0,
                             conversion_start, pulse_gen_zero_hold_clear,
                             pulse_gen_one_hold_clear, 1'b0, data_pointer_select};

   // ****************************************************************
   // aux_config_two
   // ****************************************************************
   // Reset leaves the watchdog reset off and the nvm timeout at its longest.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         aux_config_two <= `ACR_AUX_CONFIG_TWO_RESET;
      end else if (wr_aux_config_two) begin
         aux_config_two <= sfr_wdata_in;
      end
   end

   // ****************************************************************
   // aux_control_one strobes
   // ****************************************************************
   // A written 1 lives for exactly one cycle, then hardware drops it, so a
   // strobe is never left standing by a write that software does not repeat.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         watchdog_clear_strobe <= 1'b0;
      end else begin
         watchdog_clear_strobe <= wr_aux_control_one && sfr_wdata_in[`ACR_WDT_CLEAR_BIT];
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         timer_three_clear_strobe <= 1'b0;
      end else begin
         timer_three_clear_strobe <= wr_aux_control_one && sfr_wdata_in[`ACR_TMR3_CLEAR_BIT];
      end
   end

   // ****************************************************************
   // Conversion start
   // ****************************************************************
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         conversion_start <= 1'b0;
      end else if (wr_aux_control_one) begin
         // A software write wins over a coincident end of conversion, so a
         // restart issued in that cycle is not lost.
         conversion_start <= sfr_wdata_in[`ACR_CONV_START_BIT];
      end else if (conversion_done_in) begin
         conversion_start <= 1'b0;
      end
   end

   // ****************************************************************
   // Hold clears and pointer select
   // ****************************************************************
   // Each hold stays until software rewrites it; hardware never releases it.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pulse_gen_zero_hold_clear <= 1'b0;
      end else if (wr_aux_control_one) begin
         pulse_gen_zero_hold_clear <= sfr_wdata_in[`ACR_PG0_HOLD_BIT];
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pulse_gen_one_hold_clear <= 1'b0;
      end else if (wr_aux_control_one) begin
         pulse_gen_one_hold_clear <= sfr_wdata_in[`ACR_PG1_HOLD_BIT];
      end
   end

   // Only the select lives here; the pointers themselves sit in the core.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         data_pointer_select <= 1'b0;
      end else if (wr_aux_control_one) begin
         data_pointer_select <= sfr_wdata_in[`ACR_DATA_POINTER_SEL_BIT];
      end
   end

   // ****************************************************************
   // Nvm write timeout
   // ****************************************************************
   // The watch is armed only while a write is busy and a timeout is chosen;
   // dropping either one abandons the watch and clears the flag at once.
   assign nvm_armed = nvm_write_busy_in && (nvm_write_timeout_select != 2'h0);
   assign nvm_expired = (nvm_count + 20'h00001) >= nvm_limit;

   always_comb begin
      next_nvm_state = nvm_state;
      case (nvm_state)
         acr_pkg::ACR_NVM_IDLE: begin
            if (nvm_armed) begin
               next_nvm_state = acr_pkg::ACR_NVM_WAIT;
            end
         end
         acr_pkg::ACR_NVM_WAIT: begin
            if (!nvm_armed) begin
               next_nvm_state = acr_pkg::ACR_NVM_IDLE;
            end
         end
         default: begin
            next_nvm_state = acr_pkg::ACR_NVM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         nvm_state <= acr_pkg::ACR_NVM_IDLE;
      end else begin
         nvm_state <= next_nvm_state;
      end
   end

   // The count stops one short of the limit, so it never wraps however long
   // the write stays busy.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         nvm_count <= 20'h00000;
      end else if ((nvm_state != acr_pkg::ACR_NVM_WAIT) || !nvm_armed) begin
         nvm_count <= 20'h00000;
      end else if (!nvm_expired) begin
         nvm_count <= nvm_count + 20'h00001;
      end
   end

   // Flag stays up until the write finishes or the timeout is switched off.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         nvm_write_timeout_flag_out <= 1'b0;
      end else if ((nvm_state != acr_pkg::ACR_NVM_WAIT) || !nvm_armed) begin
         nvm_write_timeout_flag_out <= 1'b0;
      end else if (nvm_expired) begin
         nvm_write_timeout_flag_out <= 1'b1;
      end
   end

   // ****************************************************************
   // Watchdog reset enable
   // ****************************************************************
   // Policy 10 lets the watchdog reset only while the core runs fast or slow.
   // A mode code that is not one-hot counts as neither fast nor slow.
   assign mode_counts_watchdog = (run_mode_in == acr_pkg::ACR_MODE_FAST) ||
                                 (run_mode_in == acr_pkg::ACR_MODE_SLOW);

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         watchdog_reset_enable_out <= 1'b0;
      end else begin
         watchdog_reset_enable_out <= watchdog_reset_policy[1] &&
            (watchdog_reset_policy[0] || mode_counts_watchdog);
      end
   end

   // ****************************************************************
   // Registered configuration copies
   // ****************************************************************
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         low_power_select_out <= 1'b0;
         reference_pin_output_out <= 1'b0;
         wide_divide_select_out <= 1'b0;
         wide_muldiv_select_out <= 1'b0;
      end else begin
         // Only meaningful in idle or stop; the power unit qualifies it.
         low_power_select_out <= aux_config_two[`ACR_LOW_POWER_BIT];
         reference_pin_output_out <= aux_config_two[`ACR_REF_PIN_BIT];
         wide_divide_select_out <= aux_config_two[`ACR_WIDE_DIV_BIT];
         wide_muldiv_select_out <= aux_config_two[`ACR_WIDE_MULDIV_BIT];
      end
   end

   assign watchdog_clear_strobe_out = watchdog_clear_strobe;
   assign timer_three_clear_strobe_out = timer_three_clear_strobe;
   assign conversion_start_out = conversion_start;
   assign pulse_gen_zero_hold_clear_out = pulse_gen_zero_hold_clear;
   assign pulse_gen_one_hold_clear_out = pulse_gen_one_hold_clear;
   assign data_pointer_select_out = data_pointer_select;

   // ****************************************************************
   // Read port
   // ****************************************************************
   always_comb begin
      next_sfr_rdata = sfr_rdata_out;
      if (sfr_rd_in) begin
         if (addr_hits(sfr_addr_in, `ACR_ADDR_AUX_CONFIG_TWO)) begin
            next_sfr_rdata = aux_config_two;
         end else if (addr_hits(sfr_addr_in, `ACR_ADDR_AUX_CONTROL_ONE)) begin
            next_sfr_rdata = aux_control_one;
         end else begin
            // Unmapped addresses read zero so stale data never leaks out.
            next_sfr_rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         sfr_rdata_out <= 8'h00;
      end else begin
         sfr_rdata_out <= next_sfr_rdata;
      end
   end

endmodule // acr_aux_control_registers
`default_nettype wire

// *** rtl/acr_defines.svh ***
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define ACR_ADDR_AUX_CONFIG_TWO 8'hF7
`define ACR_ADDR_AUX_CONTROL_ONE 8'hF8

// ****************************************************************
// Field positions, aux_config_two
// ****************************************************************
`define ACR_WDT_POLICY_HI 7
`define ACR_WDT_POLICY_LO 6
`define ACR_LOW_POWER_BIT 5
`define ACR_REF_PIN_BIT 4
`define ACR_WIDE_DIV_BIT 3
`define ACR_NVM_TO_HI 2
`define ACR_NVM_TO_LO 1
`define ACR_WIDE_MULDIV_BIT 0

// ****************************************************************
// Field positions, aux_control_one
// ****************************************************************
`define ACR_WDT_CLEAR_BIT 7
`define ACR_TMR3_CLEAR_BIT 6
`define ACR_CONV_START_BIT 4
`define ACR_PG0_HOLD_BIT 3
`define ACR_PG1_HOLD_BIT 2
`define ACR_DATA_POINTER_SEL_BIT 0
`define ACR_AUX_CONTROL_ONE_WRITE_MASK 8'hDD

// ****************************************************************
// Reset values
// ****************************************************************
`define ACR_AUX_CONFIG_TWO_RESET 8'h06
`define ACR_AUX_CONTROL_ONE_RESET 8'h00

// ****************************************************************
// Timing, nvm write timeout in microseconds
// ****************************************************************
`define ACR_CLK_MHZ 125
`define ACR_NVM_TO1_US 800
`define ACR_NVM_TO2_US 3100
`define ACR_NVM_TO3_US 6200
`define ACR_NVM_TO1_CYC (`ACR_NVM_TO1_US * `ACR_CLK_MHZ)
`define ACR_NVM_TO2_CYC (`ACR_NVM_TO2_US * `ACR_CLK_MHZ)
`define ACR_NVM_TO3_CYC (`ACR_NVM_TO3_US * `ACR_CLK_MHZ)

`endif

// *** rtl/acr_pkg.sv ***
`default_nettype none
package acr_pkg;

   typedef enum logic [3:0] {
      ACR_MODE_FAST = 4'h1,
      ACR_MODE_SLOW = 4'h2,
      ACR_MODE_IDLE = 4'h4,
      ACR_MODE_STOP = 4'h8
   } acr_run_mode_t;

   typedef enum logic [1:0] {
      ACR_NVM_IDLE = 2'h1,
      ACR_NVM_WAIT = 2'h2
   } acr_nvm_state_t;

endpackage
`default_nettype wire

// *** tb/acr_aux_control_registers_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module acr_aux_control_registers_asserts (
   // Clock, reset and register port
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic sfr_wr_in,
   input wire logic sfr_rd_in,
   input wire logic [7:0] sfr_rdata_out,
   // Status in, controls out
   input wire logic [3:0] run_mode_in,
   input wire logic conversion_done_in,
   input wire logic nvm_write_busy_in,
   input wire logic watchdog_reset_enable_out,
   input wire logic low_power_select_out,
   input wire logic nvm_write_timeout_flag_out,
   input wire logic watchdog_clear_strobe_out,
   input wire logic conversion_start_out,
   input wire logic pulse_gen_zero_hold_clear_out
);
   logic wr_two;
   logic wr_one;
   assign wr_two = sfr_wr_in && (sfr_addr_in == 8'hF7);
   assign wr_one = sfr_wr_in && (sfr_addr_in == 8'hF8);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);
   // Derived controls lag the register by one cycle, so they are judged two edges on.
   property p_policy; wr_two |=> ##1 watchdog_reset_enable_out == ($past(sfr_wdata_in[7], 2)
      && ($past(sfr_wdata_in[6], 2) || $past(run_mode_in[0]) || $past(run_mode_in[1])));
   endproperty
   a_policy: assert property (p_policy) else $error("watchdog enable wrong");
   property p_low_power; wr_two |=> ##1 low_power_select_out == $past(sfr_wdata_in[5], 2);
   endproperty
   a_low_power: assert property (p_low_power) else $error("low power wrong");
   property p_wdt_clear; wr_one && sfr_wdata_in[7] |=> watchdog_clear_strobe_out
      ##1 (!watchdog_clear_strobe_out || $past(wr_one));
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) else $error("clear strobe wrong");
   property p_conv_start; wr_one |=> conversion_start_out == $past(sfr_wdata_in[4]);
   endproperty
   a_conv_start: assert property (p_conv_start) else $error("start bit wrong");
   property p_conv_done; conversion_done_in && !wr_one |=> !conversion_start_out;
   endproperty
   a_conv_done: assert property (p_conv_done) else $error("start not cleared");
   property p_pg0; wr_one |=> pulse_gen_zero_hold_clear_out == $past(sfr_wdata_in[3]);
   endproperty
   a_pg0: assert property (p_pg0) else $error("hold clear wrong");
   property p_undef; sfr_rd_in && sfr_addr_in == 8'hF8 |=>
      (sfr_rdata_out[5] == 1'b0 && sfr_rdata_out[1] == 1'b0);
   endproperty
   a_undef: assert property (p_undef) else $error("unused bits not zero");
   property p_nvm_drop; !nvm_write_busy_in |=> !nvm_write_timeout_flag_out;
   endproperty
   a_nvm_drop: assert property (p_nvm_drop) else $error("timeout flag stuck");
endmodule // acr_aux_control_registers_asserts
bind acr_aux_control_registers acr_aux_control_registers_asserts u_asserts (
   .clk_in, .sys_rst_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in,
   .sfr_rdata_out, .run_mode_in, .conversion_done_in, .nvm_write_busy_in,
   .watchdog_reset_enable_out, .low_power_select_out, .nvm_write_timeout_flag_out,
   .watchdog_clear_strobe_out, .conversion_start_out, .pulse_gen_zero_hold_clear_out);
`default_nettype wire

// *** tb/acr_aux_control_registers_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module acr_aux_control_registers_bench;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] sfr_addr_in = 8'h00;
   logic [7:0] sfr_wdata_in = 8'h00;
   logic sfr_wr_in = 1'b0;
   logic sfr_rd_in = 1'b0;
   logic [3:0] run_mode_in = 4'h1;
   logic conversion_done_in = 1'b0;
   logic nvm_write_busy_in = 1'b0;
   logic [7:0] sfr_rdata_out;
   logic [11:0] outs;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   always #4 clk_in = ~clk_in;
   acr_aux_control_registers #(.NVM_TO1_CYC(10), .NVM_TO2_CYC(20), .NVM_TO3_CYC(30)) u_dut (
      .clk_in, .sys_rst_in, .sfr_addr_in, .sfr_wdata_in, .sfr_wr_in, .sfr_rd_in,
      .sfr_rdata_out, .run_mode_in, .conversion_done_in, .nvm_write_busy_in,
      .watchdog_reset_enable_out(outs[11]), .low_power_select_out(outs[10]),
      .reference_pin_output_out(outs[9]), .wide_divide_select_out(outs[8]),
      .wide_muldiv_select_out(outs[7]), .nvm_write_timeout_flag_out(outs[6]),
      .watchdog_clear_strobe_out(outs[5]), .timer_three_clear_strobe_out(outs[4]),
      .conversion_start_out(outs[3]), .pulse_gen_zero_hold_clear_out(outs[2]),
      .pulse_gen_one_hold_clear_out(outs[1]), .data_pointer_select_out(outs[0]));
   // ****************************************************************
   // Access tasks
   // ****************************************************************
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
      end
   endtask
   // Inputs move on the falling edge so the design always samples settled values.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic dn);
      @(negedge clk_in);
      sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1'b1;
      conversion_done_in = dn;
      @(negedge clk_in);
      sfr_wr_in = 1'b0;
      conversion_done_in = 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_in);
      sfr_addr_in = a;
      sfr_rd_in = 1'b1;
      @(negedge clk_in);
      sfr_rd_in = 1'b0;
      chk({4'h0, sfr_rdata_out}, {4'h0, exp});
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic results;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // The whole sequence needs well under a thousand cycles.
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         results();
      end
   end
   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      idle(20);
      sys_rst_in = 1'b0;
      chk(outs, 12'h000);
      rd_reg(8'hF7, 8'h06);
      rd_reg(8'hF8, 8'h00);
      wr_reg(8'hF7, 8'h39, 1'b0);
      idle(1);
      chk({8'h00, outs[10:7]}, 12'h00F);
      rd_reg(8'hF7, 8'h39);
      for (int p = 0; p < 4; p++) begin
         for (int m = 0; m < 4; m++) begin
            run_mode_in = 4'h1 << m;
            wr_reg(8'hF7, {p[1:0], 6'h00}, 1'b0);
            idle(1);
            chk({11'h000, outs[11]}, {11'h000, p[1] & (p[0] | (m < 2))});
         end
      end
      chk({8'h00, outs[10:7]}, 12'h000);
      wr_reg(8'hF8, 8'hFF, 1'b0);
      chk({10'h000, outs[5:4]}, 12'h003);
      rd_reg(8'hF8, 8'h1D);
      chk({10'h000, outs[5:4]}, 12'h000);
      chk({8'h00, outs[3:0]}, 12'h00F);
      wr_reg(8'hF9, 8'hFF, 1'b1);
      chk({8'h00, outs[3:0]}, 12'h007);
      rd_reg(8'hF9, 8'h00);
      wr_reg(8'hF8, 8'h10, 1'b1);
      chk({8'h00, outs[3:0]}, 12'h008);
      wr_reg(8'hF8, 8'h22, 1'b0);
      rd_reg(8'hF8, 8'h00);
      chk({8'h00, outs[3:0]}, 12'h000);
      for (int s = 0; s < 4; s++) begin
         wr_reg(8'hF7, {5'h00, s[1:0], 1'b0}, 1'b0);
         // The second pass shows the count starts afresh after a finished write.
         for (int k = 0; k < 2; k++) begin
            nvm_write_busy_in = 1'b1;
            idle(10 * s);
            chk({11'h000, outs[6]}, 12'h000);
            idle(1);
            chk({11'h000, outs[6]}, (s > 0) ? 12'h001 : 12'h000);
            idle(3);
            chk({11'h000, outs[6]}, (s > 0) ? 12'h001 : 12'h000);
            nvm_write_busy_in = 1'b0;
            idle(2);
            chk({11'h000, outs[6]}, 12'h000);
         end
      end
      results();
   end
endmodule // acr_aux_control_registers_bench
`default_nettype wire
